// *** rtl/acsr_pkg.sv ***
// constants, field layout and timing of the front-end control and status registers
package acsr_pkg;
  localparam logic [7:0] ADDR_CFG_STATUS = 8'h00;
  localparam logic [7:0] ADDR_FAULT = 8'h01;
  localparam logic [7:0] ADDR_OUT_SEL = 8'h03;
  localparam logic [7:0] ADDR_SLEEP = 8'h04;
  localparam logic [7:0] ADDR_FEATURE = 8'h07;
  localparam int BIT_SINGLE = 5;
  localparam int BIT_WAKE_STAT = 4;
  localparam int BIT_EXT_OT = 5;
  localparam int BIT_INT_OT = 4;
  localparam int BIT_SLEEP = 7;
  localparam int BIT_SCAN_OFF = 7;
  localparam int BIT_REG_DIS = 6;
  localparam int BIT_FORCE_ON = 5;
  localparam int BIT_POR = 2;
  localparam int BIT_WAKE_DIS = 1;
  localparam int BIT_WAKE_POL = 0;
  localparam logic [7:0] OUT_SEL_WMASK = 8'hCF;
  localparam logic [7:0] FEATURE_WMASK = 8'hE3;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [3:0] SEL_OFF = 4'h0;
  localparam logic [3:0] SEL_EXT_TEMP = 4'h8;
  localparam logic [3:0] SEL_INT_TEMP = 4'h9;
  // arbitrary neutral bus address
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam int NUM_PINS = 5;
  localparam int IDX_SCL = 0;
  localparam int IDX_SDA = 1;
  localparam int IDX_WAKE = 2;
  localparam int IDX_EXT = 3;
  localparam int IDX_INT = 4;
  localparam logic [4:0] PIN_RST = 5'h03;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CLK_MHZ = 250;
  localparam int SCAN_PERIOD_MS = 640;
  localparam int SCAN_ON_MS = 5;
  localparam int SETTLE_MS = 1;
  localparam int SCAN_PERIOD_CYC = SCAN_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int SCAN_ON_CYC = SCAN_ON_MS * 1000 * CLK_MHZ;
  localparam int SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 32;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WRITE, ST_WACK, ST_READ, ST_RACK
  } acsr_state_t;
endpackage

// *** rtl/acsr_scan_if.sv ***
// carrier between register logic and divider supply timer
`timescale 1ns/1ps
`default_nettype none
interface acsr_scan_if;
  logic clear;
  logic auto_off;
  logic force_on;
  logic ext_sel;
  logic supply_on;
  logic compare_ok;
  modport ctrl(output clear, auto_off, force_on, ext_sel, input supply_on, compare_ok);
  modport timer(input clear, auto_off, force_on, ext_sel, output supply_on, compare_ok);
endinterface
`default_nettype wire

// *** rtl/acsr_scan_timer.sv ***
// divider supply scan timer and thermistor settle delay
`timescale 1ns/1ps
`default_nettype none
module acsr_scan_timer #(
  parameter int PERIOD_CYC = acsr_pkg::SCAN_PERIOD_CYC,
  parameter int ON_CYC = acsr_pkg::SCAN_ON_CYC,
  parameter int SETTLE_CYC = acsr_pkg::SETTLE_CYC,
  parameter int CW = acsr_pkg::CNT_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  acsr_scan_if.timer scan_if
);
  logic [CW-1:0] period_cnt_r;
  logic [CW-1:0] settle_cnt_r;
  logic supply_r;
  logic window;

  assign window = !scan_if.auto_off && (period_cnt_r < CW'(ON_CYC));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      period_cnt_r <= '0;
    end else if (scan_if.clear || period_cnt_r == CW'(PERIOD_CYC - 1)) begin
      period_cnt_r <= '0;
    end else begin
      period_cnt_r <= period_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      supply_r <= 1'b0;
    end else begin
      supply_r <= !scan_if.clear && (window || scan_if.force_on || scan_if.ext_sel);
    end
  end

  // settle count restarts whenever the supply drops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      settle_cnt_r <= '0;
    end else if (!supply_r) begin
      settle_cnt_r <= '0;
    end else if (settle_cnt_r != CW'(SETTLE_CYC)) begin
      settle_cnt_r <= settle_cnt_r + 1'b1;
    end
  end

  assign scan_if.supply_on = supply_r;
  assign scan_if.compare_ok = supply_r && (settle_cnt_r == CW'(SETTLE_CYC));
endmodule
`default_nettype wire

// *** rtl/acsr_top.sv ***
// control and status register bank reached over the two-wire serial bus
`timescale 1ns/1ps
`default_nettype none
module acsr_top #(
  parameter int SCAN_PERIOD_CYC = acsr_pkg::SCAN_PERIOD_CYC,
  parameter int SCAN_ON_CYC = acsr_pkg::SCAN_ON_CYC,
  parameter int SETTLE_CYC = acsr_pkg::SETTLE_CYC,
  parameter logic [6:0] DEV_ADDR = acsr_pkg::DEV_ADDR
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic wake_pin_in,
  input wire logic ext_hot_in,
  input wire logic int_hot_in,
  input wire logic feature_write_enable_in,
  output logic sleep_out,
  output logic regulator_output_en_out,
  output logic regulator_drive_en_out,
  output logic temp_divider_supply_out,
  output logic [3:0] analog_out_select_out,
  output logic mux_low_power_out,
  output logic [1:0] user_flags_out,
  output logic ext_overtemp_flag_out,
  output logic int_overtemp_flag_out
);
  ////////////////////////////////////////////////////////////////
  logic [acsr_pkg::NUM_PINS-1:0] raw;
  logic [acsr_pkg::NUM_PINS-1:0] sync1_r;
  logic [acsr_pkg::NUM_PINS-1:0] sync2_r;
  logic [acsr_pkg::NUM_PINS-1:0] sync3_r;
  logic [acsr_pkg::NUM_PINS-1:0] filt_r;
  logic [acsr_pkg::NUM_PINS-1:0] prev_r;

  assign raw = {int_hot_in, ext_hot_in, wake_pin_in, sda_in, scl_in};

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r <= acsr_pkg::PIN_RST;
      sync2_r <= acsr_pkg::PIN_RST;
      sync3_r <= acsr_pkg::PIN_RST;
      prev_r <= acsr_pkg::PIN_RST;
    end else begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      prev_r <= filt_r;
    end
  end

  // a pin change counts once the second and third stages agree
  for (genvar i = 0; i < acsr_pkg::NUM_PINS; i++) begin : g_filt
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        filt_r[i] <= acsr_pkg::PIN_RST[i];
      end else if (sync2_r[i] == sync3_r[i]) begin
        filt_r[i] <= sync3_r[i];
      end
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl = filt_r[acsr_pkg::IDX_SCL];
  assign sda = filt_r[acsr_pkg::IDX_SDA];
  assign scl_rise = scl && !prev_r[acsr_pkg::IDX_SCL];
  assign scl_fall = !scl && prev_r[acsr_pkg::IDX_SCL];
  assign start_det = scl && prev_r[acsr_pkg::IDX_SCL] && prev_r[acsr_pkg::IDX_SDA] && !sda;
  assign stop_det = scl && prev_r[acsr_pkg::IDX_SCL] && !prev_r[acsr_pkg::IDX_SDA] && sda;

  ////////////////////////////////////////////////////////////////
  acsr_pkg::acsr_state_t state_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] ptr_r;
  logic rw_r;
  logic ptr_phase_r;
  logic nack_r;
  logic sda_oe_r;
  logic wr_stb_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic rd_stb_r;
  logic [7:0] rd_addr_r;
  logic [7:0] rd_value;

  // slave side of the two-wire bus: pointer byte first, then data with auto increment
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= acsr_pkg::ST_IDLE;
      shift_r <= acsr_pkg::REG_RST;
      bit_cnt_r <= 4'h0;
      ptr_r <= acsr_pkg::REG_RST;
      rw_r <= 1'b0;
      ptr_phase_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      wr_stb_r <= 1'b0;
      wr_addr_r <= acsr_pkg::REG_RST;
      wr_data_r <= acsr_pkg::REG_RST;
      rd_stb_r <= 1'b0;
      rd_addr_r <= acsr_pkg::REG_RST;
    end else begin
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      if (start_det) begin
        state_r <= acsr_pkg::ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
      end else if (stop_det) begin
        state_r <= acsr_pkg::ST_IDLE;
        sda_oe_r <= 1'b0;
      end else begin
        unique case (state_r)
          acsr_pkg::ST_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          acsr_pkg::ST_ADDR: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == acsr_pkg::BITS_PER_BYTE) begin
              if (shift_r[7:1] == DEV_ADDR) begin
                sda_oe_r <= 1'b1;
                rw_r <= shift_r[0];
                state_r <= acsr_pkg::ST_AACK;
              end else begin
                state_r <= acsr_pkg::ST_IDLE;
              end
            end
          end
          acsr_pkg::ST_AACK: begin
            if (scl_fall) begin
              if (rw_r) begin
                sda_oe_r <= !rd_value[7];
                shift_r <= {rd_value[6:0], 1'b0};
                bit_cnt_r <= 4'h1;
                rd_stb_r <= 1'b1;
                rd_addr_r <= ptr_r;
                ptr_r <= ptr_r + 8'h01;
                state_r <= acsr_pkg::ST_READ;
              end else begin
                sda_oe_r <= 1'b0;
                bit_cnt_r <= 4'h0;
                ptr_phase_r <= 1'b1;
                state_r <= acsr_pkg::ST_WRITE;
              end
            end
          end
          acsr_pkg::ST_WRITE: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == acsr_pkg::BITS_PER_BYTE) begin
              sda_oe_r <= 1'b1;
              state_r <= acsr_pkg::ST_WACK;
              if (ptr_phase_r) begin
                ptr_r <= shift_r;
                ptr_phase_r <= 1'b0;
              end else begin
                wr_stb_r <= 1'b1;
                wr_addr_r <= ptr_r;
                wr_data_r <= shift_r;
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          acsr_pkg::ST_WACK: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              bit_cnt_r <= 4'h0;
              state_r <= acsr_pkg::ST_WRITE;
            end
          end
          acsr_pkg::ST_READ: begin
            if (scl_fall) begin
              if (bit_cnt_r == acsr_pkg::BITS_PER_BYTE) begin
                sda_oe_r <= 1'b0;
                state_r <= acsr_pkg::ST_RACK;
              end else begin
                sda_oe_r <= !shift_r[7];
                shift_r <= {shift_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          acsr_pkg::ST_RACK: begin
            if (scl_rise) begin
              nack_r <= sda;
            end else if (scl_fall) begin
              if (nack_r) begin
                state_r <= acsr_pkg::ST_IDLE;
              end else begin
                sda_oe_r <= !rd_value[7];
                shift_r <= {rd_value[6:0], 1'b0};
                bit_cnt_r <= 4'h1;
                rd_stb_r <= 1'b1;
                rd_addr_r <= ptr_r;
                ptr_r <= ptr_r + 8'h01;
                state_r <= acsr_pkg::ST_READ;
              end
            end
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe_r;

  ////////////////////////////////////////////////////////////////
  logic por_r;
  logic [7:0] out_sel_r;
  logic [7:0] feature_r;
  logic sleep_r;
  logic ext_cond_r;
  logic ext_flag_r;
  logic int_flag_r;
  logic wake_status;
  logic wake_edge;
  logic wr_out_sel;
  logic wr_sleep;
  logic wr_feature;
  logic fault_read;

  assign wr_out_sel = wr_stb_r && wr_addr_r == acsr_pkg::ADDR_OUT_SEL;
  assign wr_sleep = wr_stb_r && wr_addr_r == acsr_pkg::ADDR_SLEEP;
  assign wr_feature = wr_stb_r && wr_addr_r == acsr_pkg::ADDR_FEATURE && feature_write_enable_in;
  assign fault_read = rd_stb_r && rd_addr_r == acsr_pkg::ADDR_FAULT;

  // forced power-on clear, one cycle after the write
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      por_r <= 1'b0;
    end else begin
      por_r <= wr_feature && wr_data_r[acsr_pkg::BIT_POR];
    end
  end

  // nothing here is cleared by sleep
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_sel_r <= acsr_pkg::REG_RST;
    end else if (por_r) begin
      out_sel_r <= acsr_pkg::REG_RST;
    end else if (wr_out_sel) begin
      out_sel_r <= wr_data_r & acsr_pkg::OUT_SEL_WMASK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      feature_r <= acsr_pkg::REG_RST;
    end else if (por_r) begin
      feature_r <= acsr_pkg::REG_RST;
    end else if (wr_feature) begin
      feature_r <= wr_data_r & acsr_pkg::FEATURE_WMASK;
    end
  end

  assign wake_status = feature_r[acsr_pkg::BIT_WAKE_POL] ? filt_r[acsr_pkg::IDX_WAKE] : !filt_r[acsr_pkg::IDX_WAKE];
  assign wake_edge = !feature_r[acsr_pkg::BIT_WAKE_DIS]
    && (feature_r[acsr_pkg::BIT_WAKE_POL]
      ? (filt_r[acsr_pkg::IDX_WAKE] && !prev_r[acsr_pkg::IDX_WAKE])
      : (!filt_r[acsr_pkg::IDX_WAKE] && prev_r[acsr_pkg::IDX_WAKE]));

  // a host write in the same cycle as a wake edge wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_r <= 1'b0;
    end else if (por_r) begin
      sleep_r <= 1'b0;
    end else if (wr_sleep) begin
      sleep_r <= wr_data_r[acsr_pkg::BIT_SLEEP];
    end else if (sleep_r && wake_edge) begin
      sleep_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  acsr_scan_if scan_if ();

  assign scan_if.clear = por_r;
  assign scan_if.auto_off = feature_r[acsr_pkg::BIT_SCAN_OFF];
  assign scan_if.force_on = feature_r[acsr_pkg::BIT_FORCE_ON];
  assign scan_if.ext_sel = out_sel_r[3:0] == acsr_pkg::SEL_EXT_TEMP;

  acsr_scan_timer #(
    .PERIOD_CYC(SCAN_PERIOD_CYC),
    .ON_CYC(SCAN_ON_CYC),
    .SETTLE_CYC(SETTLE_CYC),
    .CW(acsr_pkg::CNT_W)
  ) u_scan (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .scan_if(scan_if)
  );

  // thermistor result is only trusted after the settle delay
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_cond_r <= 1'b0;
    end else if (por_r) begin
      ext_cond_r <= 1'b0;
    end else if (scan_if.compare_ok) begin
      ext_cond_r <= filt_r[acsr_pkg::IDX_EXT];
    end
  end

  // set wins over the clear-on-read
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_flag_r <= 1'b0;
      int_flag_r <= 1'b0;
    end else if (por_r) begin
      ext_flag_r <= 1'b0;
      int_flag_r <= 1'b0;
    end else begin
      ext_flag_r <= ext_cond_r || (ext_flag_r && !fault_read);
      int_flag_r <= filt_r[acsr_pkg::IDX_INT] || (int_flag_r && !fault_read);
    end
  end

  ////////////////////////////////////////////////////////////////
  always_comb begin
    rd_value = acsr_pkg::REG_RST;
    unique case (ptr_r)
      acsr_pkg::ADDR_CFG_STATUS: begin
        rd_value[acsr_pkg::BIT_SINGLE] = 1'b1;
        rd_value[acsr_pkg::BIT_WAKE_STAT] = wake_status;
      end
      acsr_pkg::ADDR_FAULT: begin
        rd_value[acsr_pkg::BIT_EXT_OT] = ext_flag_r;
        rd_value[acsr_pkg::BIT_INT_OT] = int_flag_r;
      end
      acsr_pkg::ADDR_OUT_SEL: begin
        rd_value = out_sel_r;
      end
      acsr_pkg::ADDR_SLEEP: begin
        rd_value[acsr_pkg::BIT_SLEEP] = sleep_r;
      end
      acsr_pkg::ADDR_FEATURE: begin
        rd_value = feature_r;
      end
      default: begin
        rd_value = acsr_pkg::REG_RST;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  assign sleep_out = sleep_r;
  assign regulator_output_en_out = !sleep_r && !feature_r[acsr_pkg::BIT_REG_DIS];
  assign regulator_drive_en_out = !feature_r[acsr_pkg::BIT_REG_DIS];
  assign temp_divider_supply_out = scan_if.supply_on;
  assign analog_out_select_out = out_sel_r[3:0];
  assign mux_low_power_out = out_sel_r[3:0] == acsr_pkg::SEL_OFF || out_sel_r[3:0] > acsr_pkg::SEL_INT_TEMP;
  assign user_flags_out = out_sel_r[7:6];
  assign ext_overtemp_flag_out = ext_flag_r;
  assign int_overtemp_flag_out = int_flag_r;
endmodule
`default_nettype wire

// *** testbench/acsr_host_model.sv ***
// two-wire bus host model that programs the register bank
`timescale 1ns/1ps
`default_nettype none
module acsr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A,
  parameter int HALF = 10
) (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic start();
    wt(1);
    sda_out = 1'b1;
    wt(HALF);
    scl_out = 1'b1;
    wt(HALF);
    sda_out = 1'b0;
    wt(HALF);
    scl_out = 1'b0;
  endtask
  // one bit, 1 releases the line; the line is sampled mid-high
  task automatic bit_x(input logic b, output logic r);
    sda_out = b;
    wt(HALF);
    scl_out = 1'b1;
    wt(HALF / 2);
    r = sda_in;
    wt(HALF - HALF / 2);
    scl_out = 1'b0;
  endtask
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(1'b1, ack);
  endtask
  // pointer write, then one data byte written or read with repeated start
  task automatic access(input logic [7:0] ptr, input logic rd, input logic [7:0] d, output logic [7:0] q,
                        output logic ok);
    logic [7:0] x;
    logic a0;
    logic a1;
    logic a2;
    start();
    byte_x({DEV_ADDR, 1'b0}, x, a0);
    byte_x(ptr, x, a1);
    if (rd) begin
      start();
      byte_x({DEV_ADDR, 1'b1}, x, a2);
      byte_x(8'hFF, q, x[0]);
    end else begin
      byte_x(d, x, a2);
    end
    ok = !a0 && !a1 && !a2;
    sda_out = 1'b0;
    wt(HALF);
    scl_out = 1'b1;
    wt(HALF);
    sda_out = 1'b1;
    wt(HALF);
  endtask
endmodule
`default_nettype wire

// *** testbench/acsr_top_props.sv ***
// concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module acsr_top_props #(
  parameter int SETTLE_CYC = acsr_pkg::SETTLE_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic int_hot_in,
  input wire logic sleep_out,
  input wire logic regulator_output_en_out,
  input wire logic regulator_drive_en_out,
  input wire logic temp_divider_supply_out,
  input wire logic [3:0] analog_out_select_out,
  input wire logic mux_low_power_out,
  input wire logic [1:0] user_flags_out,
  input wire logic ext_overtemp_flag_out,
  input wire logic int_overtemp_flag_out
);
  logic [15:0] on_cnt_r;
  // consecutive cycles with the divider supply on, saturating
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      on_cnt_r <= 16'h0000;
    end else if (!temp_divider_supply_out) begin
      on_cnt_r <= 16'h0000;
    end else if (on_cnt_r != 16'hFFFF) begin
      on_cnt_r <= on_cnt_r + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_sel_quiet; $stable(analog_out_select_out) [*2]; endsequence
  sequence s_reg_quiet; ($stable(sleep_out) && $stable(regulator_drive_en_out)) [*2]; endsequence
  sequence s_ext_sel; (analog_out_select_out == acsr_pkg::SEL_EXT_TEMP) [*3]; endsequence
  sequence s_int_hot; int_hot_in [*8]; endsequence
  property p_low_power;
    s_sel_quiet |-> mux_low_power_out == (analog_out_select_out == 4'h0 || analog_out_select_out > 4'h9);
  endproperty
  property p_reg_out;
    s_reg_quiet |-> regulator_output_en_out == (!sleep_out && regulator_drive_en_out);
  endproperty
  property p_ext_supply; s_ext_sel |-> temp_divider_supply_out; endproperty
  property p_sel_sleep; $rose(sleep_out) |-> $stable(analog_out_select_out); endproperty
  property p_flags_sleep; $rose(sleep_out) |-> $stable(user_flags_out); endproperty
  property p_sleep_off; $rose(sleep_out) |-> ##[0:1] !regulator_output_en_out; endproperty
  property p_int_set; s_int_hot |-> ##[0:2] int_overtemp_flag_out; endproperty
  property p_ext_settle;
    $rose(ext_overtemp_flag_out) |-> on_cnt_r >= SETTLE_CYC - 1 || $past(on_cnt_r) >= SETTLE_CYC - 1
      || $past(on_cnt_r, 2) >= SETTLE_CYC - 1;
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power flag wrong for select code");
  a_reg_out: assert property (p_reg_out) else $error("regulator output enable wrong");
  a_ext_supply: assert property (p_ext_supply) else $error("supply off with external select");
  a_sel_sleep: assert property (p_sel_sleep) else $error("select moved on sleep entry");
  a_flags_sleep: assert property (p_flags_sleep) else $error("user flags moved on sleep entry");
  a_sleep_off: assert property (p_sleep_off) else $error("regulator on while asleep");
  a_int_set: assert property (p_int_set) else $error("internal flag not set while hot");
  a_ext_settle: assert property (p_ext_settle) else $error("external flag set before settle");
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the control and status register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int PER = 400;
  localparam int ON = 40;
  localparam int SET = 10;
  logic clk_in;
  logic rst_n_in;
  logic wake;
  logic ext_hot;
  logic int_hot;
  logic fwe;
  wire logic scl;
  wire logic sda_drv;
  wire logic sda_line;
  logic sda_o;
  logic sda_oe;
  logic slp;
  logic reg_en;
  logic drv_en;
  logic sup;
  logic [3:0] sel;
  logic low_pw;
  logic [1:0] uf;
  logic ext_f;
  logic int_f;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  // open-drain line: the device only pulls low, and only the level it presents on sda_out
  assign sda_line = sda_drv & (~sda_oe | sda_o);
  acsr_top #(.SCAN_PERIOD_CYC(PER), .SCAN_ON_CYC(ON), .SETTLE_CYC(SET)) acsr_top_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .wake_pin_in(wake), .ext_hot_in(ext_hot), .int_hot_in(int_hot),
    .feature_write_enable_in(fwe), .sleep_out(slp), .regulator_output_en_out(reg_en),
    .regulator_drive_en_out(drv_en), .temp_divider_supply_out(sup), .analog_out_select_out(sel),
    .mux_low_power_out(low_pw), .user_flags_out(uf), .ext_overtemp_flag_out(ext_f),
    .int_overtemp_flag_out(int_f));
  acsr_host_model acsr_host_model_inst (.clk_in(clk_in), .sda_in(sda_line), .scl_out(scl), .sda_out(sda_drv));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      close_out();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic ok;
    acsr_host_model_inst.access(a, 1'b0, d, q, ok);
    chk("write ack", 8'h01, {7'h00, ok});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic ok;
    acsr_host_model_inst.access(a, 1'b1, 8'h00, q, ok);
    chk("read ack", 8'h01, {7'h00, ok});
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic cnt(input int n, output logic [7:0] c);
    c = 8'h00;
    repeat (n) begin
      @(negedge clk_in);
      c = c + {7'h00, sup};
    end
  endtask
  task automatic t_reset();
    chk("sleep", 8'h00, {7'h00, slp});
    chk("low power", 8'h01, {7'h00, low_pw});
    chk("reg out", 8'h01, {7'h00, reg_en});
    rdc(8'h00, 8'h20);
    rdc(8'h02, 8'h00);
    rdc(8'h03, 8'h00);
    rdc(8'h07, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_select();
    logic [7:0] c;
    wr(8'h03, 8'hFF);
    rdc(8'h03, 8'hCF);
    chk("user flags", 8'h03, {6'h00, uf});
    chk("reserved low power", 8'h01, {7'h00, low_pw});
    for (int k = 0; k < 10; k++) begin
      wr(8'h03, 8'(k));
      chk("select", 8'(k), {4'h0, sel});
      chk("low power", {7'h00, k == 0}, {7'h00, low_pw});
    end
    wr(8'h03, 8'h08);
    cnt(100, c);
    chk("ext select supply", 8'h64, c);
    wr(8'h03, 8'h05);
    $display("test select done");
  endtask
  task automatic t_feature();
    logic [7:0] c;
    fwe = 1'b0;
    wr(8'h07, 8'hA0);
    rdc(8'h07, 8'h00);
    fwe = 1'b1;
    wr(8'h07, 8'hFB);
    rdc(8'h07, 8'hE3);
    chk("drive", 8'h00, {7'h00, drv_en});
    cnt(100, c);
    chk("forced supply", 8'h64, c);
    wr(8'h07, 8'h80);
    cnt(2 * PER, c);
    chk("scan off", 8'h00, c);
    wr(8'h07, 8'h00);
    cnt(2 * PER, c);
    chk("scan on", 8'(2 * ON), c);
    $display("test feature done");
  endtask
  task automatic t_sleep();
    wr(8'h07, 8'h81);
    wr(8'h03, 8'h45);
    wr(8'h04, 8'h80);
    chk("sleep", 8'h01, {7'h00, slp});
    chk("reg out", 8'h00, {7'h00, reg_en});
    chk("select", 8'h05, {4'h0, sel});
    chk("user flags", 8'h01, {6'h00, uf});
    rdc(8'h03, 8'h45);
    wake = 1'b0;
    cyc(12);
    chk("fall no wake", 8'h01, {7'h00, slp});
    wake = 1'b1;
    cyc(12);
    chk("rise wake", 8'h00, {7'h00, slp});
    rdc(8'h00, 8'h30);
    wr(8'h07, 8'h80);
    wr(8'h04, 8'h80);
    wake = 1'b0;
    cyc(12);
    chk("fall wake", 8'h00, {7'h00, slp});
    rdc(8'h04, 8'h00);
    wr(8'h07, 8'h82);
    wr(8'h04, 8'h80);
    wake = 1'b1;
    cyc(12);
    wake = 1'b0;
    cyc(12);
    chk("wake off", 8'h01, {7'h00, slp});
    wr(8'h04, 8'h00);
    chk("link wake", 8'h00, {7'h00, slp});
    $display("test sleep done");
  endtask
  task automatic t_flags();
    int_hot = 1'b1;
    cyc(12);
    chk("int flag", 8'h01, {7'h00, int_f});
    rdc(8'h01, 8'h10);
    chk("int kept", 8'h01, {7'h00, int_f});
    int_hot = 1'b0;
    cyc(12);
    rdc(8'h01, 8'h10);
    chk("int cleared", 8'h00, {7'h00, int_f});
    wr(8'h07, 8'hA0);
    ext_hot = 1'b1;
    cyc(3 * SET);
    chk("ext flag", 8'h01, {7'h00, ext_f});
    ext_hot = 1'b0;
    cyc(3 * SET);
    rdc(8'h01, 8'h20);
    chk("ext cleared", 8'h00, {7'h00, ext_f});
    $display("test flags done");
  endtask
  task automatic t_por();
    wr(8'h03, 8'hC7);
    wr(8'h07, 8'h04);
    cyc(4);
    chk("select", 8'h00, {4'h0, sel});
    chk("user flags", 8'h00, {6'h00, uf});
    rdc(8'h07, 8'h00);
    $display("test por done");
  endtask
  initial begin
    rst_n_in = 1'b0;
    wake = 1'b1;
    ext_hot = 1'b0;
    int_hot = 1'b0;
    fwe = 1'b1;
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
    cyc(8);
    t_reset();
    t_select();
    t_feature();
    t_sleep();
    t_flags();
    t_por();
    close_out();
  end
endmodule
bind acsr_top acsr_top_props #(.SETTLE_CYC(SETTLE_CYC)) acsr_top_props_inst (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .int_hot_in(int_hot_in), .sleep_out(sleep_out),
  .regulator_output_en_out(regulator_output_en_out), .regulator_drive_en_out(regulator_drive_en_out),
  .temp_divider_supply_out(temp_divider_supply_out), .analog_out_select_out(analog_out_select_out),
  .mux_low_power_out(mux_low_power_out), .user_flags_out(user_flags_out),
  .ext_overtemp_flag_out(ext_overtemp_flag_out), .int_overtemp_flag_out(int_overtemp_flag_out));
`default_nettype wire
